// >>> pdg_pkg.sv
// Constants for the low-side gate pre-driver gating and high-side monitor setup.
// Assumes the register port is word addressed and 16 bits wide.
// Summary of operation
// - Drive enable low forces all low-side gate commands off, barring active override.
// - Pre-drive supply undervoltage forces all low-side gate commands off.
// - Five-volt supply undervoltage forces all low-side gate commands off.
// - Missing clock forces gates off only when clock-loss gating bit set; resets clear.
// - Only driver 6 override ignores drive enable; other conditions still apply.
// - Gate on needs request, no undervoltage, clock ok, and enable or override.
// - Command high pulls gate up to supply, command low pulls to ground.
// - While device reset is asserted every low-side gate is held off.
// - Each low-side driver has its own independent 2-bit edge-strength code.
// - Drain and freewheel thresholds are set through separate registers, one code each.
// - Threshold codes map to fixed voltages; 1000 and 1101 to 1111 are not legal.
// - Drivers 1,3,5,7 give battery drain and freewheel comparator results.
// - Drivers 2,4,6 give boost drain, battery drain and freewheel results.
// - For drivers 2,4,6 a microcore instruction picks boost or battery drain reference.
// - Drain compare uses rail minus threshold; freewheel uses ground plus threshold.
package pdg_pkg;
  localparam int          NUM_LOW    = 6;
  localparam int          NUM_HIGH   = 7;
  localparam int          NUM_BOOST  = 3;
  localparam int          REG_W      = 16;
  localparam int          ADDR_W     = 9;
  localparam int          THR_W      = 4;
  localparam int          SLEW_W     = 2;
  // Register offsets (word addresses)
  localparam logic [8:0]  CLOCK_BACKUP_STATE_OFS      = 9'h1a8;
  localparam logic [8:0]  LOW_DRIVER_OUTPUT_SETUP_OFS = 9'h1c2;
  localparam logic [8:0]  LOW_SETUP_STRIDE            = 9'h003;
  localparam logic [8:0]  HIGH_DRAIN_THR_A_OFS        = 9'h1f0;
  localparam logic [8:0]  HIGH_DRAIN_THR_B_OFS        = 9'h1f1;
  localparam logic [8:0]  HIGH_FREEWHEEL_THR_A_OFS    = 9'h1f2;
  localparam logic [8:0]  HIGH_FREEWHEEL_THR_B_OFS    = 9'h1f3;
  localparam logic [8:0]  HIGH_MONITOR_STATE_OFS      = 9'h1f4;
  localparam logic [8:0]  HIGH_BOOST_STATE_OFS        = 9'h1f5;
  // Field positions
  localparam int          CLK_GATE_EN_BIT  = 0;
  localparam int          PLL_LOCKED_BIT   = 1;
  localparam int          SLEW_LSB         = 0;
  localparam int          OVERRIDE_BIT     = 2;
  localparam int          FREEWHEEL_LSB    = 8;
  // Reset values
  localparam logic        CLK_GATE_EN_RST  = 1'b0;
  localparam logic [1:0]  SLEW_RST         = 2'h0;
  localparam logic        OVERRIDE_RST     = 1'b0;
  localparam logic [3:0]  THR_RST          = 4'h0;
  // Index of the one driver that may override drive enable
  localparam int          OVERRIDE_CH      = 5;
  // Gray-coded gate channel states
  typedef enum logic [1:0] {
    PDG_GATE_OFF  = 2'h0,
    PDG_GATE_ON   = 2'h1
  } pdg_gate_state_t;
endpackage : pdg_pkg

// >>> pdg_mon_if.sv
// Carrier for raw comparator results and their synchronised copies.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface pdg_mon_if #(
  parameter int WIDTH = 17
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] flag;
  modport src (output raw, input flag);
  modport snk (input raw, output flag);
endinterface : pdg_mon_if

// >>> pdg_mon_sync.sv
// Two-flop synchroniser bank for asynchronous comparator results.
// Assumes the results are slow analog levels, not pulses.
`timescale 1ns/1ps
module pdg_mon_sync #(
  parameter int WIDTH = 17
) (
  input  wire logic  i_ref_clk,
  input  wire logic  i_resetn,
  input  wire logic  i_clk_en,
  pdg_mon_if.snk     mon
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else if (i_clk_en)
    begin
      stage1 <= mon.raw;
      stage2 <= stage1;
    end
  end

  assign mon.flag = stage2;
endmodule : pdg_mon_sync

// >>> pdg_top.sv
// Low-side gate gating for six drivers plus high-side monitor configuration.
// Assumes a word-addressed 16-bit register port behind the serial interface,
// analog comparators outside, and channel requests on the system clock.
`timescale 1ns/1ps
module pdg_top #(
  parameter int NUM_LOW  = pdg_pkg::NUM_LOW,
  parameter int NUM_HIGH = pdg_pkg::NUM_HIGH
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_resetn,
  input  wire logic                       i_clk_en,
  // Register port
  input  wire logic [pdg_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic                       i_reg_wr,
  input  wire logic [pdg_pkg::REG_W-1:0]  i_reg_wdata,
  output logic      [pdg_pkg::REG_W-1:0]  o_reg_rdata,
  // Pins and supply monitors, asynchronous
  input  wire logic                       i_global_drive_enable,
  input  wire logic                       i_predrive_supply_undervolt,
  input  wire logic                       i_five_volt_supply_undervolt,
  input  wire logic                       i_pll_locked,
  // Channel logic, same clock
  input  wire logic [NUM_LOW-1:0]         i_low_request,
  input  wire logic [2:0]                 i_boost_rail_select,
  // Comparator results, asynchronous
  input  wire logic [NUM_HIGH-1:0]        i_battery_drain_cmp,
  input  wire logic [2:0]                 i_boost_drain_cmp,
  input  wire logic [NUM_HIGH-1:0]        i_freewheel_cmp,
  // Gate and analog setup outputs
  output logic      [NUM_LOW-1:0]         o_low_gate_cmd,
  output logic      [NUM_LOW-1:0]         o_low_gate_pull_up,
  output logic      [NUM_LOW-1:0]         o_low_gate_pull_down,
  output logic      [NUM_LOW*2-1:0]       o_low_slew_code,
  output logic      [NUM_HIGH*4-1:0]      o_high_drain_threshold,
  output logic      [NUM_HIGH*4-1:0]      o_high_freewheel_threshold,
  output logic      [2:0]                 o_boost_reference_sel,
  output logic      [NUM_HIGH-1:0]        o_high_drain_fault,
  output logic      [NUM_HIGH-1:0]        o_high_freewheel_fault
);
  localparam int MON_W = 2 * NUM_HIGH + 3;

  // Legal threshold codes; the gaps 1000 and 1101..1111 have no voltage
  function automatic logic pdg_thr_legal(input logic [3:0] code);
    pdg_thr_legal = (code <= 4'h7) || ((code >= 4'h9) && (code <= 4'hc));
  endfunction : pdg_thr_legal

  // Keep the old code when software writes an illegal one
  function automatic logic [3:0] pdg_thr_pick(input logic [3:0] new_code,
                                              input logic [3:0] old_code);
    pdg_thr_pick = pdg_thr_legal(new_code) ? new_code : old_code;
  endfunction : pdg_thr_pick

  // Input synchronisers
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic       drive_en_sync;
  logic       uv_pre_sync;
  logic       uv_five_sync;
  logic       clock_ok_sync;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_s1 <= 4'h2;
      pin_s2 <= 4'h2;
    end
    else if (i_clk_en)
    begin
      pin_s1 <= {i_pll_locked, i_five_volt_supply_undervolt,
                 i_predrive_supply_undervolt, i_global_drive_enable};
      pin_s2 <= pin_s1;
    end
  end

  // The predrive undervoltage flag resets high so the gates stay off until the monitors settle
  assign drive_en_sync = pin_s2[0];
  assign uv_pre_sync   = pin_s2[1];
  assign uv_five_sync  = pin_s2[2];
  assign clock_ok_sync = pin_s2[3];

  // Register storage
  logic                   clk_gate_en;
  logic [NUM_LOW-1:0]     override_bits;
  logic [NUM_LOW*2-1:0]   slew_bits;
  logic [NUM_HIGH*4-1:0]  drain_thr;
  logic [NUM_HIGH*4-1:0]  freewheel_thr;

  // Address decode
  logic                   hit_clock;
  logic [NUM_LOW-1:0]     hit_low;
  logic                   hit_drain_a;
  logic                   hit_drain_b;
  logic                   hit_fw_a;
  logic                   hit_fw_b;
  logic                   hit_mon;
  logic                   hit_boost;

  assign hit_clock   = (i_reg_addr == pdg_pkg::CLOCK_BACKUP_STATE_OFS);
  assign hit_drain_a = (i_reg_addr == pdg_pkg::HIGH_DRAIN_THR_A_OFS);
  assign hit_drain_b = (i_reg_addr == pdg_pkg::HIGH_DRAIN_THR_B_OFS);
  assign hit_fw_a    = (i_reg_addr == pdg_pkg::HIGH_FREEWHEEL_THR_A_OFS);
  assign hit_fw_b    = (i_reg_addr == pdg_pkg::HIGH_FREEWHEEL_THR_B_OFS);
  assign hit_mon     = (i_reg_addr == pdg_pkg::HIGH_MONITOR_STATE_OFS);
  assign hit_boost   = (i_reg_addr == pdg_pkg::HIGH_BOOST_STATE_OFS);

  // One setup register per low-side driver at a stride of three words
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LOW; gl++)
    begin : g_low_dec
      localparam logic [8:0] OFS = 9'(pdg_pkg::LOW_DRIVER_OUTPUT_SETUP_OFS
                                      + gl * pdg_pkg::LOW_SETUP_STRIDE);
      assign hit_low[gl] = (i_reg_addr == OFS);
    end
  endgenerate

  // Clock-loss gating bit, off after reset
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      clk_gate_en <= pdg_pkg::CLK_GATE_EN_RST;
    else if (i_clk_en && i_reg_wr && hit_clock)
      clk_gate_en <= i_reg_wdata[pdg_pkg::CLK_GATE_EN_BIT];
  end

  // Per-driver slew codes and override bits, written independently
  generate
    for (gl = 0; gl < NUM_LOW; gl++)
    begin : g_low_reg
      always_ff @(posedge i_ref_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          slew_bits[gl*2 +: 2] <= pdg_pkg::SLEW_RST;
          override_bits[gl]    <= pdg_pkg::OVERRIDE_RST;
        end
        else if (i_clk_en && i_reg_wr && hit_low[gl])
        begin
          slew_bits[gl*2 +: 2] <= i_reg_wdata[pdg_pkg::SLEW_LSB +: 2];
          override_bits[gl]    <= i_reg_wdata[pdg_pkg::OVERRIDE_BIT];
        end
      end
    end
  endgenerate

  // Threshold codes: HS1..HS4 in word A, HS5..HS7 in word B
  genvar gh;
  generate
    for (gh = 0; gh < NUM_HIGH; gh++)
    begin : g_thr
      localparam int LANE = (gh % 4) * 4;
      logic hit_d;
      logic hit_f;
      assign hit_d = (gh < 4) ? hit_drain_a : hit_drain_b;
      assign hit_f = (gh < 4) ? hit_fw_a : hit_fw_b;
      always_ff @(posedge i_ref_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          drain_thr[gh*4 +: 4]     <= pdg_pkg::THR_RST;
          freewheel_thr[gh*4 +: 4] <= pdg_pkg::THR_RST;
        end
        else if (i_clk_en && i_reg_wr)
        begin
          if (hit_d)
            drain_thr[gh*4 +: 4] <= pdg_thr_pick(i_reg_wdata[LANE +: 4],
                                                 drain_thr[gh*4 +: 4]);
          if (hit_f)
            freewheel_thr[gh*4 +: 4] <= pdg_thr_pick(i_reg_wdata[LANE +: 4],
                                                     freewheel_thr[gh*4 +: 4]);
        end
      end
    end
  endgenerate

  // Comparator synchronisers
  pdg_mon_if #(.WIDTH(MON_W)) mon_bus ();

  assign mon_bus.raw = {i_boost_drain_cmp, i_freewheel_cmp, i_battery_drain_cmp};

  pdg_mon_sync #(.WIDTH(MON_W)) u_mon_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_clk_en  (i_clk_en),
    .mon       (mon_bus.snk)
  );

  logic [NUM_HIGH-1:0] bat_flag;
  logic [NUM_HIGH-1:0] fw_flag;
  logic [2:0]          boost_flag;
  logic [NUM_HIGH-1:0] next_drain_fault;

  assign bat_flag   = mon_bus.flag[NUM_HIGH-1:0];
  assign fw_flag    = mon_bus.flag[2*NUM_HIGH-1:NUM_HIGH];
  assign boost_flag = mon_bus.flag[MON_W-1:2*NUM_HIGH];

  // Drivers 2,4,6 (indices 1,3,5) follow the microcore rail choice
  generate
    for (gh = 0; gh < NUM_HIGH; gh++)
    begin : g_drain
      if (gh % 2 == 1)
      begin : g_boost
        assign next_drain_fault[gh] = i_boost_rail_select[gh/2] ? boost_flag[gh/2]
                                                                : bat_flag[gh];
      end
      else
      begin : g_bat
        assign next_drain_fault[gh] = bat_flag[gh];
      end
    end
  endgenerate

  // Gate command conditions
  logic [NUM_LOW-1:0] enable_path;
  logic               supply_ok;
  logic               clock_ok;
  logic [NUM_LOW-1:0] next_gate_cmd;

  // Override counts only on driver 6; the others ignore their bit
  generate
    for (gl = 0; gl < NUM_LOW; gl++)
    begin : g_en
      if (gl == pdg_pkg::OVERRIDE_CH)
      begin : g_ovr
        assign enable_path[gl] = drive_en_sync | override_bits[gl];
      end
      else
      begin : g_plain
        assign enable_path[gl] = drive_en_sync;
      end
    end
  endgenerate

  assign supply_ok     = !uv_pre_sync && !uv_five_sync;
  assign clock_ok      = clock_ok_sync || !clk_gate_en;
  assign next_gate_cmd = i_low_request & enable_path
                         & {NUM_LOW{supply_ok && clock_ok}};

  // Registered outputs; reset forces all gates off
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_low_gate_cmd         <= '0;
      o_high_drain_fault     <= '0;
      o_high_freewheel_fault <= '0;
      o_boost_reference_sel  <= '0;
    end
    else if (i_clk_en)
    begin
      o_low_gate_cmd         <= next_gate_cmd;
      o_high_drain_fault     <= next_drain_fault;
      o_high_freewheel_fault <= fw_flag;
      o_boost_reference_sel  <= i_boost_rail_select;
    end
  end

  // Push-pull stage: exactly one side active at any time
  assign o_low_gate_pull_up   = o_low_gate_cmd;
  assign o_low_gate_pull_down = ~o_low_gate_cmd;

  // Analog setup straight from the register flops
  assign o_low_slew_code            = slew_bits;
  assign o_high_drain_threshold     = drain_thr;
  assign o_high_freewheel_threshold = freewheel_thr;

  // Read data selection; unmapped addresses read zero
  logic [pdg_pkg::REG_W-1:0] next_rdata;
  logic [pdg_pkg::REG_W-1:0] low_rd;

  always_comb
  begin
    low_rd = '0;
    for (int i = 0; i < NUM_LOW; i++)
    begin
      if (hit_low[i])
      begin
        low_rd[pdg_pkg::SLEW_LSB +: 2]  = slew_bits[i*2 +: 2];
        low_rd[pdg_pkg::OVERRIDE_BIT]   = override_bits[i];
      end
    end
  end

  always_comb
  begin
    next_rdata = '0;
    if (hit_clock)
    begin
      next_rdata[pdg_pkg::CLK_GATE_EN_BIT] = clk_gate_en;
      next_rdata[pdg_pkg::PLL_LOCKED_BIT]  = clock_ok_sync;
    end
    else if (|hit_low)
      next_rdata = low_rd;
    else if (hit_drain_a)
      next_rdata = drain_thr[15:0];
    else if (hit_drain_b)
      next_rdata = {4'h0, drain_thr[NUM_HIGH*4-1:16]};
    else if (hit_fw_a)
      next_rdata = freewheel_thr[15:0];
    else if (hit_fw_b)
      next_rdata = {4'h0, freewheel_thr[NUM_HIGH*4-1:16]};
    else if (hit_mon)
    begin
      next_rdata[NUM_HIGH-1:0] = o_high_drain_fault;
      next_rdata[pdg_pkg::FREEWHEEL_LSB +: NUM_HIGH] = o_high_freewheel_fault;
    end
    else if (hit_boost)
      next_rdata[2:0] = boost_flag;
  end

  // Read data lags the address by one cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= '0;
    else if (i_clk_en)
      o_reg_rdata <= next_rdata;
  end
endmodule : pdg_top

// >>> pdg_top_assertions.sv
// Port-level checker for the low-side gate gating and monitor setup block.
// Assumes it is bound into every pdg_top instance on the system clock.
`timescale 1ns/1ps
module pdg_top_assertions #(
  parameter int NUM_LOW  = 6,
  parameter int NUM_HIGH = 7
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_resetn,
  input wire logic                  i_clk_en,
  input wire logic [8:0]            i_reg_addr,
  input wire logic                  i_reg_wr,
  input wire logic [15:0]           i_reg_wdata,
  input wire logic [15:0]           o_reg_rdata,
  input wire logic                  i_global_drive_enable,
  input wire logic                  i_predrive_supply_undervolt,
  input wire logic                  i_five_volt_supply_undervolt,
  input wire logic [NUM_LOW-1:0]    i_low_request,
  input wire logic [NUM_HIGH-1:0]   i_freewheel_cmp,
  input wire logic [NUM_LOW-1:0]    o_low_gate_cmd,
  input wire logic [NUM_LOW-1:0]    o_low_gate_pull_up,
  input wire logic [NUM_LOW-1:0]    o_low_gate_pull_down,
  input wire logic [NUM_LOW*2-1:0]  o_low_slew_code,
  input wire logic [NUM_HIGH-1:0]   o_high_freewheel_fault
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Pin inputs pass 2 sync flops and 1 output flop, so allow three edges
  pull_pair_a: assert property (
    o_low_gate_pull_up == o_low_gate_cmd && o_low_gate_pull_down == ~o_low_gate_cmd)
    else $error("pull pair differs from command");
  reset_off_a: assert property (
    @(posedge i_ref_clk) disable iff (1'b0) !i_resetn |-> o_low_gate_cmd == 6'h00)
    else $error("gate on in reset");
  enable_off_a: assert property (
    (!i_global_drive_enable && i_clk_en)[*3] |=> o_low_gate_cmd[4:0] == 5'h00)
    else $error("gate on without enable");
  predrive_uv_a: assert property (
    (i_predrive_supply_undervolt && i_clk_en)[*3] |=> o_low_gate_cmd == 6'h00)
    else $error("gate on in predrive undervolt");
  five_uv_a: assert property (
    (i_five_volt_supply_undervolt && i_clk_en)[*3] |=> o_low_gate_cmd == 6'h00)
    else $error("gate on in five volt undervolt");
  request_gate_a: assert property (
    i_clk_en |=> (o_low_gate_cmd & ~$past(i_low_request)) == 6'h00)
    else $error("gate on without request");
  slew_write_a: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == 9'h1c2
    |=> o_low_slew_code[1:0] == $past(i_reg_wdata[1:0]))
    else $error("slew code not written");
  unmapped_zero_a: assert property (
    i_clk_en && i_reg_addr == 9'h000 |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  freewheel_sync_a: assert property (
    (i_clk_en && $stable(i_freewheel_cmp))[*4]
    |=> o_high_freewheel_fault == $past(i_freewheel_cmp))
    else $error("freewheel flag not synced");
endmodule : pdg_top_assertions
bind pdg_top pdg_top_assertions #(.NUM_LOW(NUM_LOW), .NUM_HIGH(NUM_HIGH)) chk (
  .i_ref_clk, .i_resetn, .i_clk_en, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
  .i_global_drive_enable, .i_predrive_supply_undervolt, .i_five_volt_supply_undervolt,
  .i_low_request, .i_freewheel_cmp, .o_low_gate_cmd, .o_low_gate_pull_up,
  .o_low_gate_pull_down, .o_low_slew_code, .o_high_freewheel_fault
);

// >>> pdg_fet_model.sv
// Behavioural external MOSFETs and monitor comparators around the block.
// Assumes source is either at the battery rail or at ground, never at boost.
`timescale 1ns/1ps
module pdg_fet_model (
  input  wire logic [27:0] i_fw_thr,
  input  wire logic [6:0]  i_src_hi,
  input  wire logic [5:0]  i_pull_up,
  input  wire logic [5:0]  i_pull_down,
  output logic      [6:0]  o_battery_cmp,
  output logic      [2:0]  o_boost_cmp,
  output logic      [6:0]  o_fw_cmp,
  output logic      [5:0]  o_gate_level
);
  // Low source sits under rail minus threshold; zero freewheel code never trips
  always_comb
  begin
    for (int k = 0; k < 7; k++)
    begin
      o_battery_cmp[k] = ~i_src_hi[k];
      o_fw_cmp[k] = ~i_src_hi[k] & (i_fw_thr[4*k +: 4] != 4'h0);
    end
  end
  // Boost rail always above source; gate floats low through its resistor
  assign o_boost_cmp = 3'h7;
  assign o_gate_level = i_pull_up & ~i_pull_down;
endmodule : pdg_fet_model

// >>> predriver_gating_and_monitor_config_tb.sv
// Register-call testbench for the gating and monitor setup block.
// Assumes pdg_top, its checker and the partner model are compiled first.
`timescale 1ns/1ps
module predriver_gating_and_monitor_config_tb;
  logic        i_ref_clk = 1'h0, i_resetn = 1'h0, i_clk_en = 1'h1, i_reg_wr = 1'h0;
  logic [8:0]  i_reg_addr = 9'h000;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic        i_global_drive_enable = 1'h0, i_predrive_supply_undervolt = 1'h0;
  logic        i_five_volt_supply_undervolt = 1'h0, i_pll_locked = 1'h1;
  logic [5:0]  i_low_request = 6'h00, o_low_gate_cmd, o_low_gate_pull_up;
  logic [5:0]  o_low_gate_pull_down, gate_level;
  logic [2:0]  i_boost_rail_select = 3'h0, i_boost_drain_cmp, o_boost_reference_sel;
  logic [6:0]  i_battery_drain_cmp, i_freewheel_cmp, o_high_drain_fault;
  logic [6:0]  o_high_freewheel_fault, src_hi = 7'h7f;
  logic [11:0] o_low_slew_code;
  logic [27:0] o_high_drain_threshold, o_high_freewheel_threshold;
  int          fails = 0, n_checks = 0, cyc = 0;

  pdg_top uut (
    .i_ref_clk                    (i_ref_clk),
    .i_resetn                     (i_resetn),
    .i_clk_en                     (i_clk_en),
    .i_reg_addr                   (i_reg_addr),
    .i_reg_wr                     (i_reg_wr),
    .i_reg_wdata                  (i_reg_wdata),
    .o_reg_rdata                  (o_reg_rdata),
    .i_global_drive_enable        (i_global_drive_enable),
    .i_predrive_supply_undervolt  (i_predrive_supply_undervolt),
    .i_five_volt_supply_undervolt (i_five_volt_supply_undervolt),
    .i_pll_locked                 (i_pll_locked),
    .i_low_request                (i_low_request),
    .i_boost_rail_select          (i_boost_rail_select),
    .i_battery_drain_cmp          (i_battery_drain_cmp),
    .i_boost_drain_cmp            (i_boost_drain_cmp),
    .i_freewheel_cmp              (i_freewheel_cmp),
    .o_low_gate_cmd               (o_low_gate_cmd),
    .o_low_gate_pull_up           (o_low_gate_pull_up),
    .o_low_gate_pull_down         (o_low_gate_pull_down),
    .o_low_slew_code              (o_low_slew_code),
    .o_high_drain_threshold       (o_high_drain_threshold),
    .o_high_freewheel_threshold   (o_high_freewheel_threshold),
    .o_boost_reference_sel        (o_boost_reference_sel),
    .o_high_drain_fault           (o_high_drain_fault),
    .o_high_freewheel_fault       (o_high_freewheel_fault)
  );
  pdg_fet_model fet (.i_fw_thr(o_high_freewheel_threshold), .i_src_hi(src_hi),
    .i_pull_up(o_low_gate_pull_up), .i_pull_down(o_low_gate_pull_down),
    .o_battery_cmp(i_battery_drain_cmp), .o_boost_cmp(i_boost_drain_cmp),
    .o_fw_cmp(i_freewheel_cmp), .o_gate_level(gate_level));

  // Free-running system clock
  always #25 i_ref_clk = ~i_ref_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; back-to-back calls never double-assign it
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wr <= 1'h1;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'h0;
  endtask : wr

  // Read data lands one edge after the address is taken
  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_reg_rdata, exp);
  endtask : rd

  // Three-edge pin path, with margin
  task automatic settle;
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask : settle

  // Bits: drive enable, predrive undervolt, five volt undervolt, clock ok
  task automatic gate(input logic [3:0] c, input logic [5:0] exp);
    @(posedge i_ref_clk);
    {i_global_drive_enable, i_predrive_supply_undervolt} <= c[3:2];
    {i_five_volt_supply_undervolt, i_pll_locked} <= c[1:0];
    settle();
    chk(o_low_gate_cmd, exp);
    chk(gate_level, exp);
  endtask : gate

  // Hang guard, well above the expected 120 or so cycles
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      $display("FAIL at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk({o_low_gate_cmd, o_low_gate_pull_down}, 12'h03f);
    repeat (6) @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    i_low_request <= 6'h3f;
    rd(9'h1c2, 16'h0000);
    rd(9'h000, 16'h0000);
    rd(9'h1a8, 16'h0002);
    gate(4'h9, 6'h3f);
    gate(4'h1, 6'h00);
    wr(9'h1c2, 16'h0004);
    wr(9'h1d1, 16'h0004);
    gate(4'h1, 6'h20);
    gate(4'h5, 6'h00);
    gate(4'h3, 6'h00);
    gate(4'h8, 6'h3f);
    wr(9'h1a8, 16'h0001);
    gate(4'h8, 6'h00);
    @(posedge i_ref_clk);
    i_low_request <= 6'h15;
    gate(4'h9, 6'h15);
    // Clock enable low freezes the gates although the request changes
    @(posedge i_ref_clk);
    i_clk_en <= 1'h0;
    i_low_request <= 6'h3f;
    settle();
    chk(o_low_gate_cmd, 6'h15);
    // Mid-run reset drops live gates even with the clock frozen
    @(posedge i_ref_clk);
    i_resetn <= 1'h0;
    @(negedge i_ref_clk);
    chk(o_low_gate_cmd, 6'h00);
    @(posedge i_ref_clk);
    i_resetn <= 1'h1;
    i_clk_en <= 1'h1;
    // Independent edge codes, one per driver
    for (int k = 0; k < 6; k++)
      wr(9'h1c2 + 9'(3 * k), 16'(k % 4));
    @(negedge i_ref_clk);
    chk(o_low_slew_code, 12'h4e4);
    rd(9'h1cb, 16'h0003);
    // Illegal lanes of the first word keep their old codes
    wr(9'h1f0, 16'h2c91);
    wr(9'h1f0, 16'h3d81);
    wr(9'h1f1, 16'h0765);
    wr(9'h1f2, 16'h1234);
    @(negedge i_ref_clk);
    chk(o_high_drain_threshold, 28'h7653c91);
    chk(o_high_freewheel_threshold, 28'h0001234);
    @(posedge i_ref_clk);
    i_boost_rail_select <= 3'h2;
    settle();
    chk({o_high_freewheel_fault, o_high_drain_fault}, 14'h0008);
    chk(o_boost_reference_sel, 3'h2);
    @(posedge i_ref_clk);
    src_hi <= 7'h55;
    i_boost_rail_select <= 3'h0;
    settle();
    chk({o_high_freewheel_fault, o_high_drain_fault}, {7'h0a, 7'h2a});
    rd(9'h1f4, 16'h0a2a);
    rd(9'h1f5, 16'h0007);
    report_and_stop();
  end
endmodule : predriver_gating_and_monitor_config_tb
